// ===== src/fsr_bank.sv
// status and configuration register bank of a serial flash, spi side
// assumes spi mode 0: SCK idle low, data sampled on rising edge, msb first;
// SCK, CS_N, SI and WP_N are asynchronous and are synchronised to CLK.
// Notes on behaviour
// - top/bottom bit picks array end, default top
// - top/bottom changes only via permitted status write
// - granularity bit selects 4KB or 64KB units
// - complement bit s14 inverts protected region
// - both locks clear: write needs only latch
// - protect bit set, pin low: writes refused
// - protect bit set, pin high: latch suffices
// - lock-down refuses writes until power cycle
// - prefix AAh 55h makes lock permanent
// - pin gates writes only outside quad mode
// - suspend 75h sets paused flag s15
// - resume 7Ah or power cycle clears flag
// - three security locks s13..s11 individually settable
// - security locks clear only on por with rstn low
// - quad enable low keeps hold, no quad
// - quad enable high frees lines, disables hold
// - scheme bit selects level bits or locks
// - individual locks all set on reset
// - strength field decodes 100/75/50/25, default 25
// - reserved bits unaffected by writes
// - completed status write clears write latch
// - program/erase into protected region ignored
`timescale 1ns/10ps
module fsr_bank #(
    parameter int LOCKS = fsr_pkg::LOCK_COUNT
)(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        POR_N,
    input  wire logic        SCK,
    input  wire logic        CS_N,
    input  wire logic        SI,
    input  wire logic        WP_N,
    input  wire logic        QUAD_ACTIVE,
    input  wire logic        PE_REQ,
    input  wire logic [21:0] PE_ADDR,
    input  wire logic        PE_SECTOR,
    input  wire logic        LOCK_WR,
    input  wire logic [6:0]  LOCK_IDX,
    input  wire logic        LOCK_VAL,
    output logic             SO,
    output logic             SO_OE,
    output logic             PE_GRANT,
    output logic             PE_DONE,
    output logic             HOLD_ENABLE,
    output logic             QUAD_ALLOWED,
    output logic [6:0]       DRIVE_PCT,
    output logic [2:0]       SECURITY_RO,
    output logic             PAUSED
);
    ////////////////////////////////////////////////////////////////////////
    // synchronisers
    logic [1:0] sck_s;   // clock pin
    logic [1:0] cs_s;    // chip select
    logic [1:0] si_s;    // data in
    logic [1:0] wp_s;    // write protect pin
    logic       sck_d;   // previous synced clock for edge finding

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            sck_s <= 2'b00;
            cs_s  <= 2'b11;
            si_s  <= 2'b00;
            wp_s  <= 2'b11;
            sck_d <= 1'b0;
        end
        else
        begin
            sck_s <= {sck_s[0], SCK};
            cs_s  <= {cs_s[0], CS_N};
            si_s  <= {si_s[0], SI};
            wp_s  <= {wp_s[0], WP_N};
            sck_d <= sck_s[1];
        end
    end

    logic sck_rise;  // sample point
    logic sck_fall;  // shift-out point
    logic sel;       // frame active
    assign sck_rise = sel && sck_s[1] && !sck_d;
    assign sck_fall = sel && !sck_s[1] && sck_d;
    assign sel      = !cs_s[1];

    ////////////////////////////////////////////////////////////////////////
    // byte deserialiser
    logic [2:0]  bit_r;     // bit within byte
    logic [7:0]  shf_r;     // shift register in
    logic [2:0]  nbyte_r;   // bytes taken this frame, saturating
    logic [7:0]  op_r;      // opcode of frame
    logic [15:0] data_r;    // up to two data bytes
    logic        byte_done; // full byte this cycle
    logic [7:0]  byte_val;  // that byte
    assign byte_done = sck_rise && (bit_r == 3'h7);
    assign byte_val  = {shf_r[6:0], si_s[1]};

    // shifts in on rising edges, restarts per frame
    always_ff @(posedge CLK)
    begin
        if (!RSTN || !sel)
        begin
            bit_r   <= 3'h0;
            shf_r   <= 8'h00;
            nbyte_r <= 3'h0;
            op_r    <= 8'h00;
            data_r  <= 16'h0000;
        end
        else if (sck_rise)
        begin
            bit_r <= bit_r + 3'h1;
            shf_r <= byte_val;
            if (byte_done)
            begin
                if (nbyte_r == 3'h0)
                    op_r <= byte_val;
                else if (nbyte_r < 3'h3)
                    data_r <= {data_r[7:0], byte_val};
                if (nbyte_r != 3'h7)
                    nbyte_r <= nbyte_r + 3'h1;
            end
        end
    end

    // frame end: detect cs rising
    logic sel_d;  // delayed frame flag
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            sel_d <= 1'b0;
        else
            sel_d <= sel;
    end
    logic frame_end;  // one-cycle pulse at cs release
    assign frame_end = sel_d && !sel;

    ////////////////////////////////////////////////////////////////////////
    // status word and write gate
    logic [23:0] stat_r;     // volatile status copy
    logic        perm_r;     // permanent status lock
    logic [1:0]  pfx_r;      // prefix progress
    logic        wr_ok;      // status writes allowed
    logic        wr_cmd;     // a well-formed write status frame ended
    logic [23:0] wr_word;    // incoming bits placed at their positions
    logic [23:0] wr_sel;     // positions this write touches

    // srl/srp/pin gate; pin only counts outside quad mode
    assign wr_ok = stat_r[fsr_pkg::BIT_WEL] && !perm_r
                 && !stat_r[fsr_pkg::BIT_SRL]
                 && (!stat_r[fsr_pkg::BIT_SRP]
                     || QUAD_ACTIVE
                     || wp_s[1]);

    // only exact byte counts commit; partial frames drop
    always_comb
    begin
        wr_cmd  = 1'b0;
        wr_word = 24'h000000;
        wr_sel  = 24'h000000;
        if (frame_end && bit_r == 3'h0)
        begin
            if (op_r == fsr_pkg::OP_WRSR1 && nbyte_r == 3'h3)
            begin
                wr_cmd  = 1'b1;
                wr_word = {8'h00, data_r[7:0], data_r[15:8]};
                wr_sel  = 24'h00ffff;
            end
            else if (op_r == fsr_pkg::OP_WRSR1 && nbyte_r == 3'h2)
            begin
                wr_cmd  = 1'b1;
                wr_word = {16'h0000, data_r[7:0]};
                wr_sel  = 24'h0000ff;
            end
            else if (op_r == fsr_pkg::OP_WRSR2 && nbyte_r == 3'h2)
            begin
                wr_cmd  = 1'b1;
                wr_word = {8'h00, data_r[7:0], 8'h00};
                wr_sel  = 24'h00ff00;
            end
            else if (op_r == fsr_pkg::OP_WRSR3 && nbyte_r == 3'h2)
            begin
                wr_cmd  = 1'b1;
                wr_word = {data_r[7:0], 16'h0000};
                wr_sel  = 24'hff0000;
            end
        end
    end

    logic        frame_op;  // a one-byte instruction frame ended
    assign frame_op = frame_end && nbyte_r == 3'h1 && bit_r == 3'h0;

    // prefix tracker: AAh frame, then 55h frame, then the write
    always_ff @(posedge CLK)
    begin
        if (!POR_N)
            pfx_r <= 2'h0;
        else if (frame_op && op_r == fsr_pkg::OP_PFX_A)
            pfx_r <= 2'h1;
        else if (frame_op && op_r == fsr_pkg::OP_PFX_B && pfx_r == 2'h1)
            pfx_r <= 2'h2;
        else if (frame_end)
            pfx_r <= 2'h0;
    end

    // permanent lock survives power cycles of this model unless rstn is low as well
    always_ff @(posedge CLK)
    begin
        if (!RSTN && !POR_N)
            perm_r <= 1'b0;
        else if (wr_cmd && wr_ok && pfx_r == 2'h2 && wr_word[fsr_pkg::BIT_SRL])
            perm_r <= 1'b1;
    end

    // status bits; por models the power cycle, rstn a soft reset
    always_ff @(posedge CLK)
    begin
        if (!POR_N)
            stat_r <= fsr_pkg::RST_STAT | (RSTN ? stat_r & (24'h7 << fsr_pkg::BIT_LB1) : 24'h0);
        else if (!RSTN)
            stat_r[fsr_pkg::BIT_WEL] <= 1'b0;
        else if (wr_cmd)
        begin
            if (wr_ok)
            begin
                // masked write; reserved bits stay put
                stat_r <= (stat_r & ~(wr_sel & fsr_pkg::WR_MASK))
                        | (wr_word & wr_sel & fsr_pkg::WR_MASK)
                        | (stat_r & (24'h7 << fsr_pkg::BIT_LB1))
                        | (wr_word & wr_sel & (24'h7 << fsr_pkg::BIT_LB1));
            end
            stat_r[fsr_pkg::BIT_WEL] <= 1'b0;
        end
        else if (frame_op && op_r == fsr_pkg::OP_WREN)
            stat_r[fsr_pkg::BIT_WEL] <= 1'b1;
        else if (frame_op && op_r == fsr_pkg::OP_WRDI)
            stat_r[fsr_pkg::BIT_WEL] <= 1'b0;
        else if (frame_op && op_r == fsr_pkg::OP_SUSPEND)
            stat_r[fsr_pkg::BIT_SUS] <= 1'b1;
        else if (frame_op && op_r == fsr_pkg::OP_RESUME)
            stat_r[fsr_pkg::BIT_SUS] <= 1'b0;
        else if (PE_DONE)
            stat_r[fsr_pkg::BIT_WEL] <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // status read-out, shifted on falling edges
    logic [7:0] out_r;  // byte being shifted out
    always_ff @(posedge CLK)
    begin
        if (!RSTN || !sel)
            out_r <= 8'h00;
        else if (sck_fall && bit_r == 3'h0 && nbyte_r != 3'h0)
        begin
            if (op_r == fsr_pkg::OP_RDSR1)
                out_r <= stat_r[7:0];
            else if (op_r == fsr_pkg::OP_RDSR2)
                out_r <= stat_r[15:8];
            else if (op_r == fsr_pkg::OP_RDSR3)
                out_r <= stat_r[23:16];
            else
                out_r <= 8'h00;
        end
        else if (sck_fall)
            out_r <= {out_r[6:0], 1'b0};
    end
    assign SO    = out_r[7];
    assign SO_OE = sel && nbyte_r != 3'h0
                 && (op_r == fsr_pkg::OP_RDSR1 || op_r == fsr_pkg::OP_RDSR2 || op_r == fsr_pkg::OP_RDSR3);

    ////////////////////////////////////////////////////////////////////////
    // configuration outputs
    logic [1:0] drv;  // strength field
    assign drv          = stat_r[fsr_pkg::BIT_DRV0 +: 2];
    assign DRIVE_PCT    = (drv == 2'b00) ? fsr_pkg::DRV_PCT0 :
                          (drv == 2'b01) ? fsr_pkg::DRV_PCT1 :
                          (drv == 2'b10) ? fsr_pkg::DRV_PCT2 : fsr_pkg::DRV_PCT3;
    assign HOLD_ENABLE  = !stat_r[fsr_pkg::BIT_QE];
    assign QUAD_ALLOWED = stat_r[fsr_pkg::BIT_QE];
    assign SECURITY_RO  = stat_r[fsr_pkg::BIT_LB1 +: 3];
    assign PAUSED       = stat_r[fsr_pkg::BIT_SUS];

    ////////////////////////////////////////////////////////////////////////
    // array protection check for program/erase requests
    logic [2:0] bp;      // protect level
    logic [5:0] ublk;    // 64KB block index of target
    logic [3:0] usec;    // 4KB sector within block
    logic       hit;     // target inside level-bit region
    logic       pe_r;    // request in check, second cycle
    logic [6:0] lk_idx;  // individual lock index of target
    assign bp   = stat_r[fsr_pkg::BIT_BP0 +: 3];
    assign ublk = PE_ADDR[21:16];
    assign usec = PE_ADDR[15:12];

    // region decode; a block request into the edge block counts as protected whole
    always_comb
    begin
        logic [5:0] b;
        logic [3:0] s;
        logic [3:0] n;
        b   = stat_r[fsr_pkg::BIT_TB] ? ublk : ~ublk;
        s   = stat_r[fsr_pkg::BIT_TB] ? usec : ~usec;
        n   = 4'h0;
        hit = 1'b0;
        if (bp == 3'h7)
            hit = 1'b1;
        else if (bp == 3'h0)
            hit = 1'b0;
        else if (!stat_r[fsr_pkg::BIT_SEC])
            hit = (int'(b) < (1 << (int'(bp) - 1)));
        else
        begin
            n   = (bp[2]) ? 4'h8 : (4'h1 << (bp[1:0] - 2'h1));
            hit = (b == 6'h00) && ((s < n) || !PE_SECTOR);
        end
        if (stat_r[fsr_pkg::BIT_CMP])
            hit = !hit || (!PE_SECTOR && bp != 3'h0 && stat_r[fsr_pkg::BIT_SEC] && b == 6'h00);
    end

    // lock index: edge blocks by sector, others by block
    assign lk_idx = (ublk == 6'h00) ? {3'h0, usec}
                  : (ublk == 6'h3f) ? 7'h10 + {3'h0, usec}
                  : 7'h1f + {1'b0, ublk};

    fsr_lock_if #(.N(LOCKS), .AW(7)) lk ();
    assign lk.wr_en  = LOCK_WR;
    assign lk.wr_idx = LOCK_IDX;
    assign lk.wr_val = LOCK_VAL;
    assign lk.rd_idx = lk_idx;

    fsr_lock_mem #(.N(LOCKS)) u_locks (
        .clk   (CLK),
        .rst_n (RSTN),
        .lk    (lk.store)
    );

    logic hit_r;  // level-bit verdict held for the lock lookup cycle
    // two-cycle check: lookup is registered in the store
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            pe_r     <= 1'b0;
            hit_r    <= 1'b0;
            PE_GRANT <= 1'b0;
            PE_DONE  <= 1'b0;
        end
        else
        begin
            pe_r     <= PE_REQ && stat_r[fsr_pkg::BIT_WEL];
            hit_r    <= hit;
            PE_DONE  <= pe_r;
            // scheme select picks locks or level bits
            PE_GRANT <= pe_r && (stat_r[fsr_pkg::BIT_WPS] ? !lk.rd_val : !hit_r);
        end
    end
endmodule

// ===== src/fsr_pkg.sv
// shared constants for the flash status/protect register bank
// assumes a standard spi mode 0 host; bit positions are status word bits s0..s23
package fsr_pkg;
    // instruction opcodes
    localparam logic [7:0] OP_WREN    = 8'h06;  // write enable
    localparam logic [7:0] OP_WRDI    = 8'h04;  // write disable
    localparam logic [7:0] OP_RDSR1   = 8'h05;  // read status one
    localparam logic [7:0] OP_RDSR2   = 8'h35;  // read status two
    localparam logic [7:0] OP_RDSR3   = 8'h15;  // read status three
    localparam logic [7:0] OP_WRSR1   = 8'h01;  // write status one
    localparam logic [7:0] OP_WRSR2   = 8'h31;  // write status two
    localparam logic [7:0] OP_WRSR3   = 8'h11;  // write status three
    localparam logic [7:0] OP_SUSPEND = 8'h75;  // erase/program suspend
    localparam logic [7:0] OP_RESUME  = 8'h7a;  // erase/program resume
    localparam logic [7:0] OP_PFX_A   = 8'haa;  // permanent lock prefix, first byte
    localparam logic [7:0] OP_PFX_B   = 8'h55;  // permanent lock prefix, second byte
    // field positions inside the 24-bit status word
    localparam int BIT_WEL  = 1;   // write enable latch
    localparam int BIT_BP0  = 2;   // protect level low bit
    localparam int BIT_TB   = 5;   // top/bottom select
    localparam int BIT_SEC  = 6;   // sector granularity
    localparam int BIT_SRP  = 7;   // status write protect
    localparam int BIT_SRL  = 8;   // status lock down
    localparam int BIT_QE   = 9;   // quad io enable
    localparam int BIT_LB1  = 11;  // first security lock bit
    localparam int BIT_CMP  = 14;  // complement protect
    localparam int BIT_SUS  = 15;  // paused operation flag
    localparam int BIT_WPS  = 18;  // protect scheme select
    localparam int BIT_DRV0 = 21;  // output strength low bit
    // bits that a status write may change (lock bits handled separately)
    localparam logic [23:0] WR_MASK   = 24'h6443fc;
    // reset values of the volatile copy of the status word (strength 11)
    localparam logic [23:0] RST_STAT  = 24'h600000;
    // output strength percentages
    localparam logic [6:0] DRV_PCT0 = 7'h64;  // 100
    localparam logic [6:0] DRV_PCT1 = 7'h4b;  // 75
    localparam logic [6:0] DRV_PCT2 = 7'h32;  // 50
    localparam logic [6:0] DRV_PCT3 = 7'h19;  // 25
    // region sizes in address bits
    localparam int SECTOR_SHIFT = 12;  // 4KB
    localparam int BLOCK_SHIFT  = 16;  // 64KB
    localparam int ADDR_W       = 22;  // array address width
    localparam int LOCK_COUNT   = 94;  // individual lock bits
endpackage

// ===== src/fsr_lock_if.sv
// carrier between the bank and the individual lock store
// assumes both ends on the same clock
`timescale 1ns/10ps
interface fsr_lock_if #(parameter int N = 94, parameter int AW = 7);
    logic          wr_en;    // write one lock bit
    logic [AW-1:0] wr_idx;   // lock bit index
    logic          wr_val;   // new value
    logic [AW-1:0] rd_idx;   // looked-up index
    logic          rd_val;   // registered lookup
    modport bank  (output wr_en, output wr_idx, output wr_val, output rd_idx, input rd_val);
    modport store (input wr_en, input wr_idx, input wr_val, input rd_idx, output rd_val);
endinterface

// ===== src/fsr_lock_mem.sv
// individual sector/block lock store, one bit per region
// assumes synchronous active-low reset shared with the bank
`timescale 1ns/10ps
module fsr_lock_mem #(
    parameter int N = 94
)(
    input  wire logic clk,
    input  wire logic rst_n,
    fsr_lock_if.store lk
);
    logic [N-1:0] lock_r;  // lock bits, 1 = protected

    ////////////////////////////////////////////////////////////////////////
    // every lock sets on reset; single writes otherwise
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            lock_r <= '1;
        else if (lk.wr_en && (int'(lk.wr_idx) < N))
            lock_r[lk.wr_idx] <= lk.wr_val;
    end

    // registered read port
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            lk.rd_val <= 1'b1;
        else
            lk.rd_val <= (int'(lk.rd_idx) < N) ? lock_r[lk.rd_idx] : 1'b1;
    end
endmodule

// ===== sim/fsr_bank_properties.sv
// checker on the ports of the status and protect bank
// assumes one clock domain and synchronous active-low resets
`timescale 1ns/10ps
module fsr_bank_properties #(
    parameter int LOCKS = 94
)(
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        POR_N,
    input wire logic        SCK,
    input wire logic        CS_N,
    input wire logic        SI,
    input wire logic        WP_N,
    input wire logic        QUAD_ACTIVE,
    input wire logic        PE_REQ,
    input wire logic [21:0] PE_ADDR,
    input wire logic        PE_SECTOR,
    input wire logic        LOCK_WR,
    input wire logic [6:0]  LOCK_IDX,
    input wire logic        LOCK_VAL,
    input wire logic        SO,
    input wire logic        SO_OE,
    input wire logic        PE_GRANT,
    input wire logic        PE_DONE,
    input wire logic        HOLD_ENABLE,
    input wire logic        QUAD_ALLOWED,
    input wire logic [6:0]  DRIVE_PCT,
    input wire logic [2:0]  SECURITY_RO,
    input wire logic        PAUSED
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////////////
    // strength output only ever takes one of the four settings
    property p_drive_legal;
        DRIVE_PCT inside {7'h64, 7'h4b, 7'h32, 7'h19};
    endproperty
    a_drive_legal: assert property (p_drive_legal) else $error("strength off table");
    // hold and quad lines are exclusive uses of the same pins
    property p_hold_quad;
        HOLD_ENABLE == !QUAD_ALLOWED;
    endproperty
    a_hold_quad: assert property (p_hold_quad) else $error("hold and quad clash");
    // a power cycle leaves default strength, no pause, hold on
    property p_por_defaults;
        !POR_N |=> DRIVE_PCT == 7'h19 && !PAUSED && HOLD_ENABLE;
    endproperty
    a_por_defaults: assert property (p_por_defaults) else $error("power cycle defaults");
    // security locks only ever gain bits; only a full reset clears them
    property p_sec_sticky;
        disable iff (!RSTN && !POR_N) ($past(SECURITY_RO) & ~SECURITY_RO) == 3'h0;
    endproperty
    a_sec_sticky: assert property (p_sec_sticky) else $error("security lock cleared");
    // a grant needs a request two cycles before
    property p_grant_cause;
        PE_GRANT |-> $past(PE_REQ, 2);
    endproperty
    a_grant_cause: assert property (p_grant_cause) else $error("grant without request");
    // a granted request completes, which drops the latch
    property p_grant_done;
        PE_GRANT |-> PE_DONE;
    endproperty
    a_grant_done: assert property (p_grant_done) else $error("grant without done");
    // paused flag rises only after a frame has closed
    property p_pause_rise;
        $rose(PAUSED) |-> CS_N && $past(CS_N, 3);
    endproperty
    a_pause_rise: assert property (p_pause_rise) else $error("pause inside frame");
    // paused flag falls only at frame close or power cycle
    property p_pause_fall;
        $fell(PAUSED) |-> CS_N || !$past(POR_N);
    endproperty
    a_pause_fall: assert property (p_pause_fall) else $error("pause cleared early");
    // status levels never move while a frame is open
    property p_quiet_in_frame;
        $changed(DRIVE_PCT) || $changed(SECURITY_RO) || $changed(QUAD_ALLOWED) |-> CS_N;
    endproperty
    a_quiet_in_frame: assert property (p_quiet_in_frame) else $error("status moved in frame");
    // serial output only driven inside a frame
    property p_oe_frame;
        SO_OE |-> !$past(CS_N, 2);
    endproperty
    a_oe_frame: assert property (p_oe_frame) else $error("output outside frame");
endmodule

// ===== sim/fsr_host_model.sv
// serial host model for the status bank
// assumes mode 0 and a link clock of eight system clocks (200 ns)
`timescale 1ns/10ps
module fsr_host_model (
    input wire logic CLK,
    input wire logic SO,
    output logic     SCK,
    output logic     CS_N,
    output logic     SI
);
    // link clock parked low, chip deselected
    initial
    begin
        SCK = 1'b0;
        CS_N = 1'b1;
        SI = 1'b0;
    end
    // one frame: top nb bits of b, msb first; rd keeps last eight read
    task automatic shift(input logic [23:0] b, input int nb, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge CLK) CS_N <= 1'b0;
        for (int i = 0; i < nb; i++)
        begin
            @(posedge CLK) SI <= b[23-i];
            repeat (3) @(posedge CLK);
            SCK <= 1'b1;
            // mid-high sample, clear of the synchroniser delay
            repeat (2) @(posedge CLK);
            rd = {rd[6:0], SO};
            repeat (2) @(posedge CLK);
            SCK <= 1'b0;
        end
        repeat (4) @(posedge CLK);
        CS_N <= 1'b1;
        // a released line must not keep showing the last bit
        SI <= ~SI;
        repeat (8) @(posedge CLK);
    endtask
endmodule

// ===== sim/fsr_bank_tb_top.sv
// self-checking bench for the status and protect bank
// assumes the host model is the only serial master
`timescale 1ns/10ps
module fsr_bank_tb_top;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        por_n = 1'b0;
    logic        wp_n = 1'b1;
    logic        quad_act = 1'b0;
    logic        pe_req = 1'b0;
    logic [21:0] pe_addr = 22'h000000;
    logic        pe_sec = 1'b0;
    logic        lk_wr = 1'b0;
    logic [6:0]  lk_idx = 7'h00;
    logic        lk_val = 1'b0;
    logic        sck, cs_n, si, so, so_oe, grant, done, hold, quad_ok, paused;
    logic [6:0]  pct;
    logic [2:0]  sec_ro;
    logic [7:0]  tbl [4] = '{8'h64, 8'h4b, 8'h32, 8'h19};
    int          bad_count = 0;
    int          check_count = 0;
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    fsr_host_model fsr_host_model_i (.CLK(clk), .SO(so), .SCK(sck), .CS_N(cs_n), .SI(si));
    fsr_bank #(.LOCKS(94)) fsr_bank_i (
        .CLK(clk), .RSTN(rstn), .POR_N(por_n), .SCK(sck), .CS_N(cs_n), .SI(si), .WP_N(wp_n),
        .QUAD_ACTIVE(quad_act), .PE_REQ(pe_req), .PE_ADDR(pe_addr), .PE_SECTOR(pe_sec),
        .LOCK_WR(lk_wr), .LOCK_IDX(lk_idx), .LOCK_VAL(lk_val), .SO(so), .SO_OE(so_oe),
        .PE_GRANT(grant), .PE_DONE(done), .HOLD_ENABLE(hold), .QUAD_ALLOWED(quad_ok),
        .DRIVE_PCT(pct), .SECURITY_RO(sec_ro), .PAUSED(paused));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        logic [7:0] j;
        fsr_host_model_i.shift({op, 16'h0000}, 8, j);
    endtask
    // write enable, then a one-byte status write
    task automatic wr(input logic [7:0] op, input logic [7:0] d);
        logic [7:0] j;
        cmd(8'h06);
        fsr_host_model_i.shift({op, d, 8'h00}, 16, j);
    endtask
    task automatic rd(input logic [7:0] op, input logic [7:0] exp);
        logic [7:0] v;
        fsr_host_model_i.shift({op, 16'h0000}, 16, v);
        // reserved bits may read either way, so they are ignored
        v = v & (op == 8'h35 ? 8'hfb : op == 8'h15 ? 8'h64 : 8'hff);
        chk(v, exp);
    endtask
    // program/erase request with latch set; exp is the grant
    task automatic pe(input logic [21:0] a, input logic s, input logic exp);
        logic g;
        g = 1'b0;
        cmd(8'h06);
        @(posedge clk);
        pe_req <= 1'b1;
        pe_addr <= a;
        pe_sec <= s;
        @(posedge clk);
        pe_req <= 1'b0;
        repeat (5) @(posedge clk) g = g | grant;
        chk({7'h00, g}, {7'h00, exp});
    endtask
    task automatic por();
        @(posedge clk);
        por_n <= 1'b0;
        repeat (2) @(posedge clk);
        por_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] j;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h05, 8'h00);
        rd(8'h35, 8'h00);
        rd(8'h15, 8'h60);
        chk({7'h00, hold}, 8'h01);
        fsr_host_model_i.shift({8'h01, 8'h1c, 8'h00}, 16, j);
        rd(8'h05, 8'h00);
        cmd(8'h06);
        fsr_host_model_i.shift({8'h01, 8'h1c, 8'h00}, 12, j);
        rd(8'h05, 8'h02);
        wr(8'h01, 8'h7c);
        rd(8'h05, 8'h7c);
        for (int d = 0; d < 4; d++)
        begin
            wr(8'h11, 8'(d << 5));
            chk({1'b0, pct}, tbl[d]);
        end
        wr(8'h31, 8'h02);
        chk({6'h00, hold, quad_ok}, 8'h01);
        wr(8'h31, 8'h00);
        chk({6'h00, hold, quad_ok}, 8'h02);
        $display("register writes done");
        wr(8'h01, 8'h80);
        wp_n <= 1'b0;
        wr(8'h01, 8'h84);
        rd(8'h05, 8'h80);
        quad_act <= 1'b1;
        wr(8'h01, 8'h84);
        rd(8'h05, 8'h84);
        quad_act <= 1'b0;
        wp_n <= 1'b1;
        wr(8'h01, 8'h88);
        rd(8'h05, 8'h88);
        $display("write gating done");
        pe(22'h3f0000, 1'b0, 1'b0);
        pe(22'h000000, 1'b0, 1'b1);
        wr(8'h01, 8'ha8);
        pe(22'h000000, 1'b0, 1'b0);
        cmd(8'h06);
        fsr_host_model_i.shift({8'h01, 8'ha8, 8'h40}, 24, j);
        rd(8'h35, 8'h40);
        pe(22'h000000, 1'b0, 1'b1);
        pe(22'h3f0000, 1'b0, 1'b0);
        wr(8'h31, 8'h00);
        wr(8'h01, 8'he4);
        pe(22'h001000, 1'b1, 1'b1);
        pe(22'h000000, 1'b1, 1'b0);
        wr(8'h11, 8'h04);
        pe(22'h200000, 1'b0, 1'b0);
        @(posedge clk);
        lk_wr <= 1'b1;
        lk_idx <= 7'h3f;
        @(posedge clk);
        lk_wr <= 1'b0;
        pe(22'h200000, 1'b0, 1'b1);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        pe(22'h200000, 1'b0, 1'b0);
        $display("array protection done");
        cmd(8'h75);
        chk({7'h00, paused}, 8'h01);
        rd(8'h35, 8'h80);
        cmd(8'h7a);
        chk({7'h00, paused}, 8'h00);
        cmd(8'h75);
        por();
        chk({7'h00, paused}, 8'h00);
        wr(8'h31, 8'h08);
        chk({5'h00, sec_ro}, 8'h01);
        wr(8'h31, 8'h10);
        rd(8'h35, 8'h18);
        wr(8'h31, 8'h19);
        wr(8'h01, 8'h1c);
        rd(8'h05, 8'h00);
        por();
        wr(8'h01, 8'h1c);
        rd(8'h05, 8'h1c);
        cmd(8'h06);
        cmd(8'haa);
        cmd(8'h55);
        fsr_host_model_i.shift({8'h31, 8'h01, 8'h00}, 16, j);
        por();
        wr(8'h01, 8'h1c);
        rd(8'h05, 8'h00);
        $display("locks and suspend done");
        wrap_up();
    end
endmodule
bind fsr_bank fsr_bank_properties #(.LOCKS(LOCKS)) fsr_bank_properties_i (
    .CLK(CLK), .RSTN(RSTN), .POR_N(POR_N), .SCK(SCK), .CS_N(CS_N), .SI(SI), .WP_N(WP_N),
    .QUAD_ACTIVE(QUAD_ACTIVE), .PE_REQ(PE_REQ), .PE_ADDR(PE_ADDR), .PE_SECTOR(PE_SECTOR),
    .LOCK_WR(LOCK_WR), .LOCK_IDX(LOCK_IDX), .LOCK_VAL(LOCK_VAL), .SO(SO), .SO_OE(SO_OE),
    .PE_GRANT(PE_GRANT), .PE_DONE(PE_DONE), .HOLD_ENABLE(HOLD_ENABLE), .QUAD_ALLOWED(QUAD_ALLOWED),
    .DRIVE_PCT(DRIVE_PCT), .SECURITY_RO(SECURITY_RO), .PAUSED(PAUSED));
